// ### tfu_filter_stage_model.sv
// Filter stage model: a texel sink whose ready may stall at random
`timescale 1ns/1ps
`default_nettype none
module tfu_filter_stage_model (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Texel stream
   input wire logic stall_en,
   output logic out_ready
);
   logic [7:0] lfsr_reg;

   // Ready moves only just after an edge, so a taken texel is never torn
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lfsr_reg <= 8'hA5;
         out_ready <= 1'b0;
      end else begin
         lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
         out_ready <= !stall_en || (lfsr_reg[0] ^ lfsr_reg[6]);
      end
   end
endmodule // tfu_filter_stage_model
`default_nettype wire

// ### tfu_pkg.sv
// Constants and types shared by the texel format unpacker
package tfu_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [10:0] CTRL_OFFSET = 11'h000;
   localparam logic [10:0] STATUS_OFFSET = 11'h004;
   localparam logic [10:0] COUNT_OFFSET = 11'h008;
   localparam logic [10:0] PALETTE_BASE = 11'h400;
   localparam int unsigned CTRL_FMT_LSB = 0;
   localparam int unsigned CTRL_MONO_BIT = 4;
   localparam int unsigned CTRL_ALPHA_LSB = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000FF00;
   localparam int unsigned STAT_FMT_ERR_BIT = 0;
   localparam int unsigned STAT_OUT_VALID_BIT = 1;
   localparam logic [31:0] PALETTE_RESET = 32'h00000000;
   localparam logic [31:0] COUNT_RESET = 32'h00000000;

   // ---------------------------------------------------------------
   // Compressed block layout
   // ---------------------------------------------------------------
   localparam int unsigned BC_SEL0_LSB = 29;
   localparam int unsigned BC_SEL1_LSB = 26;
   localparam int unsigned BC_DIFF_BIT = 25;
   localparam int unsigned BC_FLIP_BIT = 24;
   localparam int unsigned BC_IDX_MSB_BASE = 32;
   localparam int unsigned BC_IDX_LSB_BASE = 48;
   localparam logic [3:0] BC_IDX_ROT = 4'h8;
   // Offset magnitudes per column, table 0 (tsel 0) in the low byte
   localparam logic [63:0] LUM_SMALL = 64'h2F21_1812_0D09_0502;
   localparam logic [63:0] LUM_BIG = 64'hB76A_503C_2A1D_1108;

   // ---------------------------------------------------------------
   // Formats and bus states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      FMT_RGBA8 = 4'h0,
      FMT_INTENSITY8 = 4'h1,
      FMT_LUMINANCE8 = 4'h2,
      FMT_LUMINANCE8_ALPHA8 = 4'h3,
      FMT_ONE_BIT_MONO = 4'h4,
      FMT_BYTE_MONO = 4'h5,
      FMT_HIGH_ALPHA_NIBBLE_PAL = 4'h6,
      FMT_LOW_ALPHA_NIBBLE_PAL = 4'h7,
      FMT_HIGH_ALPHA_BYTE_PAL = 4'h8,
      FMT_LOW_ALPHA_BYTE_PAL = 4'h9,
      FMT_BYTE_INDEX_PAL = 4'hA,
      FMT_TWO_BIT_INDEX_PAL = 4'hB,
      FMT_BLOCK_COMPRESSED_RGB = 4'hC
   } tfu_fmt_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } tfu_bus_t;
endpackage

// ### tfu_tb.sv
// Self-checking bench for the texel format unpacker
`timescale 1ns/1ps
`default_nettype none
module tb import tfu_pkg::*;;
   logic clk = 1'b0;
   logic nrst, avs_read, avs_write, avs_waitrequest, in_valid, in_ready, out_valid, out_ready;
   logic stall_en, mono_sh;
   logic [10:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rnd, exp_w;
   logic [3:0] avs_byteenable, fmt_sh;
   logic [63:0] in_data;
   logic [5:0] in_sel;
   logic [7:0] out_red, out_green, out_blue, out_alpha, dflt_sh;
   logic [31:0] pal [256];
   logic [31:0] expq [$];
   int error_cnt = 0;
   int comparisons = 0;
   int seed, i, f, k;
   int sml [8] = '{2, 5, 9, 13, 18, 24, 33, 47};
   int big [8] = '{8, 17, 29, 42, 60, 80, 106, 183};

   always #25 clk = ~clk;

   tfu_texel_format_unpacker dut (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .in_valid, .in_data, .in_sel, .in_ready,
      .out_valid, .out_ready, .out_red, .out_green, .out_blue, .out_alpha);
   tfu_filter_stage_model u_sink (.clk, .nrst, .stall_en, .out_ready);

   task automatic finish_test;
      if (error_cnt == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Reference texel as {red, green, blue, alpha}
   function automatic logic [31:0] model(input logic [63:0] d, input logic [5:0] s);
      logic [7:0] b;
      logic [15:0] h;
      logic [31:0] w, res;
      int r, c, sb, ch, v, o, ix, m;
      b = d[{s[2:0], 3'h0} +: 8];
      h = d[{s[1:0], 4'h0} +: 16];
      w = d[{s[0], 5'h00} +: 32];
      if (mono_sh && fmt_sh != 4'h5) return 32'h0;
      case (fmt_sh)
         4'h0: return {w[7:0], w[15:8], w[23:16], w[31:24]};
         4'h1: return {4{b}};
         4'h2: return {b, b, b, dflt_sh};
         4'h3: return {h[7:0], h[7:0], h[7:0], h[15:8]};
         4'h4, 4'h5: return {32{d[s]}};
         4'h6: return {pal[b[3:0]][23:0], b[7:4], b[7:4]};
         4'h7: return {pal[b[7:4]][23:0], b[3:0], b[3:0]};
         4'h8: return {pal[h[7:0]][23:0], h[15:8]};
         4'h9: return {pal[h[15:8]][23:0], h[7:0]};
         4'hA: return {pal[b][23:0], pal[b][31:24]};
         4'hB: return {pal[b[1:0]][23:0], pal[b[1:0]][31:24]};
         4'hC: begin
            r = s[3:2];
            c = s[1:0];
            sb = d[24] ? r / 2 : c / 2;
            ix = 2 * d[32 + (4 * c + r + 8) % 16] + d[48 + (4 * c + r + 8) % 16];
            m = sb ? d[28:26] : d[31:29];
            o = (ix % 2 ? big[m] : sml[m]) * (ix >= 2 ? -1 : 1);
            for (ch = 0; ch < 3; ch++) begin
               if (d[25]) begin
                  v = d[8 * ch + 3 +: 5];
                  if (sb) v = (v + $signed(d[8 * ch +: 3])) & 31;
                  v = v * 8 + v / 4;
               end else begin
                  v = sb ? d[8 * ch +: 4] : d[8 * ch + 4 +: 4];
                  v = v * 17;
               end
               v = v + o;
               res[31 - 8 * ch -: 8] = 8'(v < 0 ? 0 : (v > 255 ? 255 : v));
            end
            res[7:0] = 8'hFF;
            return res;
         end
         default: return 32'h0;
      endcase
   endfunction

   task automatic bus(input logic wr, input logic [10:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      // A bus that never answers counts as a mismatch
      chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [10:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdc(input logic [10:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk($sformatf("reg_%h", a), e, q);
   endtask

   task automatic send(input logic [63:0] d, input logic [5:0] s);
      int n;
      in_valid <= 1'b1;
      in_data <= d;
      in_sel <= s;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (in_ready !== 1'b1 && n < 200);
      chk("in_ready", 32'h1, {31'h0, in_ready});
      expq.push_back(model(d, s));
   endtask

   // Control only changes once every texel in flight has left
   task automatic set_ctrl(input logic [3:0] fm, input logic mo, input logic [7:0] al);
      int n;
      in_valid <= 1'b0;
      n = 0;
      while (expq.size() != 0 && n < 500) begin
         @(posedge clk);
         n++;
      end
      chk("drain", 32'h0, expq.size());
      fmt_sh = fm;
      mono_sh = mo;
      dflt_sh = al;
      // Formats are only ever sampled here, never used as a render target
      wr(CTRL_OFFSET, {16'h0, al, 3'h0, mo, fm});
   endtask

   always @(posedge clk) begin
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
         exp_w = expq.size() > 0 ? expq.pop_front() : 32'hX;
         chk("texel", exp_w, {out_red, out_green, out_blue, out_alpha});
      end
   end

   initial begin
      #2000000;
      error_cnt++;
      finish_test;
   end

   initial begin
      seed = 49604;
      nrst = 1'b0;
      {avs_read, avs_write, in_valid, stall_en} = 4'h0;
      avs_address = 11'h000;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      in_data = 64'h0;
      in_sel = 6'h0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rdc(CTRL_OFFSET, CTRL_RESET);
      rdc(STATUS_OFFSET, 32'h0);
      rdc(COUNT_OFFSET, COUNT_RESET);
      rdc(PALETTE_BASE, PALETTE_RESET);
      wr(11'h00C, 32'hFFFFFFFF);
      rdc(11'h00C, 32'h0);
      wr(COUNT_OFFSET, 32'h0000FFFF);
      for (i = 0; i < 256; i++) begin
         pal[i] = $random(seed);
         wr(PALETTE_BASE + 11'(i * 4), pal[i]);
      end
      rdc(PALETTE_BASE + 11'h3FC, pal[255]);
      // Every format code, then mono filter with a legal and an illegal format
      for (f = 0; f < 18; f++) begin
         rnd = $random(seed);
         set_ctrl(f < 16 ? 4'(f) : (f == 16 ? 4'h5 : 4'h4), f >= 16, rnd[7:0]);
         stall_en <= f[0];
         for (k = 0; k < 20; k++) begin
            rnd = $random(seed);
            send({$random(seed), rnd}, rnd[5:0]);
         end
      end
      set_ctrl(4'h0, 1'b0, 8'hFF);
      rdc(STATUS_OFFSET, 32'h1);
      wr(STATUS_OFFSET, 32'h1);
      rdc(STATUS_OFFSET, 32'h0);
      rdc(COUNT_OFFSET, 32'h168);
      finish_test;
   end
endmodule // tb
`default_nettype wire

// ### tfu_texel_format_unpacker.sv
// Texel format unpacker: surface words in, RGBA texels out
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module tfu_texel_format_unpacker import tfu_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Avalon-MM register slave
   input wire logic [10:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Surface word stream
   input wire logic in_valid,
   input wire logic [63:0] in_data,
   input wire logic [5:0] in_sel,
   output logic in_ready,
   // Texel stream to the filter stage
   output logic out_valid,
   input wire logic out_ready,
   output logic [7:0] out_red,
   output logic [7:0] out_green,
   output logic [7:0] out_blue,
   output logic [7:0] out_alpha
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Palette entries are ARGB with blue lowest; texels carry red lowest
   function automatic logic [31:0] argb_to_rgba(input logic [31:0] e);
      return {e[31:24], e[7:0], e[15:8], e[23:16]};
   endfunction

   function automatic logic [7:0] clamp_add(input logic [7:0] base,
      input logic [8:0] off);
      logic signed [9:0] s;
      s = $signed({2'b00, base}) + $signed({off[8], off});
      if (s < 0) begin
         return 8'h00;
      end else if (s > 10'sd255) begin
         return 8'hFF;
      end
      return s[7:0];
   endfunction

   // Decodes one texel of the compressed block; pos is {row, col}
   function automatic logic [23:0] bc_texel(input logic [63:0] b,
      input logic [3:0] pos);
      logic sub;
      logic [3:0] bitpos;
      logic idx_msb;
      logic idx_lsb;
      logic [2:0] tsel;
      logic [7:0] mag;
      logic [8:0] off;
      logic [7:0] field;
      logic [4:0] base5;
      logic [3:0] base4;
      logic [7:0] wide;
      logic [23:0] rgb;
      sub = b[BC_FLIP_BIT] ? pos[3] : pos[1];
      bitpos = {pos[1:0], pos[3:2]} + BC_IDX_ROT;
      idx_msb = b[BC_IDX_MSB_BASE + 32'(bitpos)];
      idx_lsb = b[BC_IDX_LSB_BASE + 32'(bitpos)];
      tsel = sub ? b[BC_SEL1_LSB +: 3] : b[BC_SEL0_LSB +: 3];
      // Index LSB picks the large column, MSB negates
      mag = idx_lsb ? LUM_BIG[{tsel, 3'b000} +: 8] : LUM_SMALL[{tsel, 3'b000} +: 8];
      off = idx_msb ? 9'(-{1'b0, mag}) : {1'b0, mag};
      rgb = 24'h000000;
      for (int c = 0; c < 3; c++) begin
         field = b[c*8 +: 8];
         if (b[BC_DIFF_BIT]) begin
            base5 = field[7:3];
            if (sub) begin
               // Out-of-range sums wrap; the result is undefined anyway
               base5 = base5 + {{2{field[2]}}, field[2:0]};
            end
            wide = {base5, base5[4:2]};
         end else begin
            base4 = sub ? field[3:0] : field[7:4];
            wide = {base4, base4};
         end
         rgb[c*8 +: 8] = clamp_add(wide, off);
      end
      return rgb;
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   tfu_bus_t bus_state_reg;
   logic [31:0] ctrl_reg;
   logic fmt_err_reg;
   logic [31:0] count_reg;
   logic [31:0] palette_reg [256];
   logic [31:0] out_texel_reg;
   logic out_valid_reg;
   logic [31:0] skid_texel_reg;
   logic skid_valid_reg;
   logic in_ready_reg;
   logic [31:0] readdata_reg;
   logic waitrequest_reg;

   tfu_fmt_t fmt;
   logic mono_filter;
   logic [7:0] default_alpha;
   logic bus_req;
   logic wr_commit;
   logic [31:0] rd_mux;
   logic in_fire;
   logic out_fire;
   logic skid_valid_next;
   logic bad_fmt;
   logic [7:0] pix8;
   logic [15:0] pix16;
   logic [31:0] pix32;
   logic pix1;
   logic [7:0] pal_idx;
   logic [31:0] pal_entry;
   logic [31:0] decoded;

   assign fmt = tfu_fmt_t'(ctrl_reg[CTRL_FMT_LSB +: 4]);
   assign mono_filter = ctrl_reg[CTRL_MONO_BIT];
   assign default_alpha = ctrl_reg[CTRL_ALPHA_LSB +: 8];

   // ---------------------------------------------------------------
   // Register bus
   // ---------------------------------------------------------------
   assign bus_req = avs_read | avs_write;
   // Master holds the request through the ack cycle, so commit there
   assign wr_commit = (bus_state_reg == BUS_ACK) && avs_write;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus_state_reg <= BUS_IDLE;
      end else begin
         case (bus_state_reg)
            BUS_IDLE: begin
               if (bus_req) begin
                  bus_state_reg <= BUS_ACK;
               end
            end
            BUS_ACK: begin
               bus_state_reg <= BUS_IDLE;
            end
            default: begin
               bus_state_reg <= BUS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         waitrequest_reg <= 1'b1;
      end else begin
         waitrequest_reg <= !((bus_state_reg == BUS_IDLE) && bus_req);
      end
   end

   always_comb begin
      rd_mux = 32'h00000000;
      if (avs_address[10]) begin
         rd_mux = palette_reg[avs_address[9:2]];
      end else if (avs_address == CTRL_OFFSET) begin
         rd_mux = ctrl_reg;
      end else if (avs_address == STATUS_OFFSET) begin
         rd_mux[STAT_FMT_ERR_BIT] = fmt_err_reg;
         rd_mux[STAT_OUT_VALID_BIT] = out_valid_reg;
      end else if (avs_address == COUNT_OFFSET) begin
         rd_mux = count_reg;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         readdata_reg <= 32'h00000000;
      end else if ((bus_state_reg == BUS_IDLE) && avs_read) begin
         readdata_reg <= rd_mux;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg <= CTRL_RESET;
      end else if (wr_commit && (avs_address == CTRL_OFFSET)) begin
         ctrl_reg <= be_merge(ctrl_reg, avs_writedata, avs_byteenable);
      end
   end

   // A mismatch arriving with the clearing write still sets the flag
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fmt_err_reg <= 1'b0;
      end else if (in_fire && bad_fmt) begin
         fmt_err_reg <= 1'b1;
      end else if (wr_commit && (avs_address == STATUS_OFFSET) &&
                   avs_byteenable[0] && avs_writedata[STAT_FMT_ERR_BIT]) begin
         fmt_err_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_reg <= COUNT_RESET;
      end else if (out_fire) begin
         count_reg <= count_reg + 32'h00000001;
      end
   end

   // Palette filled by register bus writes at PALETTE_BASE before sampling
   for (genvar e = 0; e < 256; e++) begin : g_palette
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            palette_reg[e] <= PALETTE_RESET;
         end else if (wr_commit && avs_address[10] && (avs_address[9:2] == 8'(e))) begin
            palette_reg[e] <= be_merge(palette_reg[e], avs_writedata, avs_byteenable);
         end
      end
   end

   // ---------------------------------------------------------------
   // Texel decode
   // ---------------------------------------------------------------
   // Byte k of the word is bits 8k+7:8k, i.e. little endian
   assign pix8 = in_data[{in_sel[2:0], 3'b000} +: 8];
   assign pix16 = in_data[{in_sel[1:0], 4'h0} +: 16];
   assign pix32 = in_data[{in_sel[0], 5'h00} +: 32];
   assign pix1 = in_data[in_sel];
   // The mono filter takes byte mono alone
   assign bad_fmt = mono_filter && (fmt != FMT_BYTE_MONO);

   always_comb begin
      case (fmt)
         FMT_HIGH_ALPHA_NIBBLE_PAL: pal_idx = {4'h0, pix8[3:0]};
         FMT_LOW_ALPHA_NIBBLE_PAL: pal_idx = {4'h0, pix8[7:4]};
         FMT_HIGH_ALPHA_BYTE_PAL: pal_idx = pix16[7:0];
         FMT_LOW_ALPHA_BYTE_PAL: pal_idx = pix16[15:8];
         FMT_BYTE_INDEX_PAL: pal_idx = pix8;
         FMT_TWO_BIT_INDEX_PAL: pal_idx = {6'h00, pix8[1:0]};
         default: pal_idx = 8'h00;
      endcase
   end

   assign pal_entry = argb_to_rgba(palette_reg[pal_idx]);

   // Texels pack red in 7:0 up to alpha in 31:24
   // An 8-bit unorm code already equals value/255 on the filter side
   always_comb begin
      case (fmt)
         FMT_RGBA8: decoded = pix32;
         FMT_INTENSITY8: decoded = {4{pix8}};
         FMT_LUMINANCE8: decoded = {default_alpha, {3{pix8}}};
         FMT_LUMINANCE8_ALPHA8: decoded = {pix16[15:8], {3{pix16[7:0]}}};
         FMT_ONE_BIT_MONO, FMT_BYTE_MONO: begin
            decoded = {32{pix1}};
         end
         FMT_HIGH_ALPHA_NIBBLE_PAL: begin
            decoded = {pix8[7:4], pix8[7:4], pal_entry[23:0]};
         end
         FMT_LOW_ALPHA_NIBBLE_PAL: begin
            decoded = {pix8[3:0], pix8[3:0], pal_entry[23:0]};
         end
         FMT_HIGH_ALPHA_BYTE_PAL: decoded = {pix16[15:8], pal_entry[23:0]};
         FMT_LOW_ALPHA_BYTE_PAL: decoded = {pix16[7:0], pal_entry[23:0]};
         FMT_BYTE_INDEX_PAL, FMT_TWO_BIT_INDEX_PAL: decoded = pal_entry;
         FMT_BLOCK_COMPRESSED_RGB: begin
            decoded = {8'hFF, bc_texel(in_data, in_sel[3:0])};
         end
         default: decoded = 32'h00000000;
      endcase
      // Rejected format still yields a texel so the stream stays aligned
      if (bad_fmt) begin
         decoded = 32'h00000000;
      end
   end

   // ---------------------------------------------------------------
   // Output handshake with skid slot
   // ---------------------------------------------------------------
   // The skid slot lets in_ready come from a flop at full rate
   assign in_fire = in_valid && in_ready_reg;
   assign out_fire = out_valid_reg && out_ready;

   always_comb begin
      skid_valid_next = skid_valid_reg;
      if (!out_valid_reg || out_fire) begin
         skid_valid_next = 1'b0;
      end else if (in_fire) begin
         skid_valid_next = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         out_valid_reg <= 1'b0;
         out_texel_reg <= 32'h00000000;
      end else if (!out_valid_reg || out_fire) begin
         if (skid_valid_reg) begin
            out_valid_reg <= 1'b1;
            out_texel_reg <= skid_texel_reg;
         end else begin
            out_valid_reg <= in_fire;
            if (in_fire) begin
               out_texel_reg <= decoded;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         skid_valid_reg <= 1'b0;
         skid_texel_reg <= 32'h00000000;
      end else begin
         skid_valid_reg <= skid_valid_next;
         if (out_valid_reg && !out_ready && in_fire) begin
            skid_texel_reg <= decoded;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         in_ready_reg <= 1'b0;
      end else begin
         in_ready_reg <= !skid_valid_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign avs_readdata = readdata_reg;
   assign avs_waitrequest = waitrequest_reg;
   assign in_ready = in_ready_reg;
   assign out_valid = out_valid_reg;
   assign out_red = out_texel_reg[7:0];
   assign out_green = out_texel_reg[15:8];
   assign out_blue = out_texel_reg[23:16];
   assign out_alpha = out_texel_reg[31:24];

endmodule // tfu_texel_format_unpacker
`default_nettype wire

// ### tfu_unpacker_asserts.sv
// Port checker for the texel format unpacker
`timescale 1ns/1ps
`default_nettype none
module tfu_unpacker_asserts import tfu_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register bus
   input wire logic [10:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Texel streams
   input wire logic in_valid,
   input wire logic [63:0] in_data,
   input wire logic [5:0] in_sel,
   input wire logic in_ready,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [7:0] out_red,
   input wire logic [7:0] out_green,
   input wire logic [7:0] out_blue,
   input wire logic [7:0] out_alpha
);
   logic [3:0] fmt_reg;
   logic mono_reg;
   logic [7:0] dflt_reg;
   logic take_reg;
   logic [63:0] data_reg;
   logic [5:0] sel_reg;
   logic [7:0] byte_w;
   logic [15:0] half_w;
   logic [31:0] word_w;
   logic [31:0] rgba_w;
   logic plain_w;

   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   // Shadow of the control word, as committed on the bus
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fmt_reg <= CTRL_RESET[3:0];
         mono_reg <= CTRL_RESET[4];
         dflt_reg <= CTRL_RESET[15:8];
      end else if (avs_write && !avs_waitrequest && avs_address == CTRL_OFFSET) begin
         if (avs_byteenable[0]) begin
            fmt_reg <= avs_writedata[3:0];
            mono_reg <= avs_writedata[4];
         end
         if (avs_byteenable[1]) begin
            dflt_reg <= avs_writedata[15:8];
         end
      end
   end

   // A texel taken while the output is free must show up next cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         take_reg <= 1'b0;
         data_reg <= 64'h0;
         sel_reg <= 6'h0;
      end else begin
         take_reg <= in_valid && in_ready && (!out_valid || out_ready);
         data_reg <= in_data;
         sel_reg <= in_sel;
      end
   end

   assign byte_w = data_reg[{sel_reg[2:0], 3'h0} +: 8];
   assign half_w = data_reg[{sel_reg[1:0], 4'h0} +: 16];
   assign word_w = data_reg[{sel_reg[0], 5'h00} +: 32];
   assign rgba_w = {out_red, out_green, out_blue, out_alpha};
   assign plain_w = take_reg && !mono_reg;

   AST_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(rgba_w))
      else $error("texel changed while stalled");
   AST_ANSWER: assert property (in_valid && in_ready && (!out_valid || out_ready) |=> out_valid)
      else $error("taken texel not presented next cycle");
   AST_SKID: assert property (in_valid && in_ready && out_valid && !out_ready |=> !in_ready)
      else $error("input still ready with skid full");
   AST_RGBA: assert property (plain_w && fmt_reg == 4'h0 |-> rgba_w == {word_w[7:0], word_w[15:8], word_w[23:16], word_w[31:24]})
      else $error("byte order wrong");
   AST_INTENS: assert property (plain_w && fmt_reg == 4'h1 |-> rgba_w == {4{byte_w}})
      else $error("intensity not replicated");
   AST_LUMA: assert property (plain_w && fmt_reg == 4'h2 |-> rgba_w == {byte_w, byte_w, byte_w, dflt_reg})
      else $error("luminance or default alpha wrong");
   AST_MONO: assert property (plain_w && (fmt_reg == 4'h4 || fmt_reg == 4'h5) |-> rgba_w == {32{data_reg[sel_reg]}})
      else $error("mono bit wrong");
   AST_MONO_FILT: assert property (take_reg && mono_reg && fmt_reg != 4'h5 |-> rgba_w == 32'h0)
      else $error("mono filter accepted a wrong format");
   AST_NIB_ALPHA: assert property (plain_w && fmt_reg[3:1] == 3'h3 |-> out_alpha == (fmt_reg[0] ? {2{byte_w[3:0]}} : {2{byte_w[7:4]}}))
      else $error("nibble alpha wrong");
   AST_BYTE_ALPHA: assert property (plain_w && fmt_reg[3:1] == 3'h4 |-> out_alpha == (fmt_reg[0] ? half_w[7:0] : half_w[15:8]))
      else $error("byte alpha wrong");

   cover property (out_valid && !out_ready);
   cover property (take_reg && fmt_reg == 4'hC);
   cover property (take_reg && mono_reg && fmt_reg != 4'h5);
endmodule // tfu_unpacker_asserts

bind tfu_texel_format_unpacker tfu_unpacker_asserts u_asserts (.clk, .nrst, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .in_valid, .in_data,
   .in_sel, .in_ready, .out_valid, .out_ready, .out_red, .out_green, .out_blue, .out_alpha);
`default_nettype wire
